// file: gfx_parser_consts.vh
// Purpose: constants for the command parser status block
// Assumes: apb byte addresses, 32-bit data
// Notes: definitions only
`ifndef GFX_PARSER_CONSTS_VH
`define GFX_PARSER_CONSTS_VH

`define ADDR_ENGINE_CONTROL 12'h000
`define ADDR_PARSER_STATUS 12'h004
`define ADDR_IRQ_STATUS 12'h020
`define ADDR_IRQ_MASK 12'h024

`define CTRL_SEQ_HI 31
`define CTRL_SEQ_LO 16
`define CTRL_ONECOMP_BIT 4
`define CTRL_SEQ_EN_BIT 3
`define CTRL_ABORT_BIT 2
`define CTRL_RESTART_BIT 1
`define CTRL_ENABLE_BIT 0

`define STAT_SEQ_HI 31
`define STAT_SEQ_LO 16
`define STAT_SUB_HI 11
`define STAT_SUB_LO 8
`define STAT_REASON_HI 7
`define STAT_REASON_LO 4
`define STAT_RD_BIT 3
`define STAT_WR_BIT 2
`define STAT_STATE_HI 1
`define STAT_STATE_LO 0

`define SEQ_RESET 16'h0000
`define NIBBLE_RESET 4'h0
`define IRQ_RESET 3'h0

`define REASON_BAD_CMD 4'h1
`define REASON_BAD_ONECOMP 4'h2
`define REASON_BAD_SEQ 4'h3
`define REASON_CMD_CHECK 4'h4
`define REASON_DP_ERR_LAST 4'h7
`define REASON_ABORT_IDLE 4'he
`define REASON_ABORT_EXEC 4'hf

`define STATE_IDLE 2'h0
`define STATE_EXEC 2'h1
`define STATE_STALL 2'h2

`define IRQ_DONE_BIT 0
`define IRQ_ERROR_BIT 1
`define IRQ_ABORT_BIT 2
`define IRQ_WIDTH 3

`endif

// file: gfx_parser_status.v
// Purpose: command parser state, error report and path activity, on apb
// Assumes: engine events arrive as one-cycle pulses on pclk
// Notes: irq status and mask words sit after the command info words
// How it works
// - status bits 31:16 hold the expected next sequence, loaded from the control word.
// - each completed command advances the expected sequence by one.
// - for a command-specific failure the subtype nibble names the failed check.
// - a restart clears both the subtype and the reason nibbles.
// - whenever the parser stalls on an error the reason nibble records the cause.
// - reasons 1 to 4 are bad command, bad ones complement, bad sequence, failed check.
// - reasons 5 to 7 are datapath errors and 8 to 13 are never reported.
// - an abort while idle reports reason 14.
// - an abort while executing reports reason 15.
// - the read path flag is 0 only with no reads outstanding and its fifo empty.
// - the write path flag is 0 only with converter, pending and fifos all quiet.
// - while stalled the converter and data fifo are left out of the write flag.
// - bits 1:0 show the state as 0 idle, 1 executing, 2 stalled.
// - a new initial sequence applies only on restart or enable rising.
// - a self-clearing abort stalls the endpoint until software restarts.
// - a self-clearing restart leaves the stall and flushes the pixel path.
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
`include "gfx_parser_consts.vh"
module gfx_parser_status #(
  parameter SEQ_WIDTH = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cmd_start,
  input wire cmd_done,
  input wire err_valid,
  input wire [3:0] err_reason,
  input wire [3:0] err_check,
  input wire rd_outstanding,
  input wire rd_fifo_empty,
  input wire pix_conv_busy,
  input wire cmds_pending,
  input wire cmd_fifo_empty,
  input wire data_fifo_empty,
  output reg engine_run_enable,
  output reg seq_check_en,
  output reg onecomp_check_en,
  output reg endpoint_stall,
  output reg pixel_flush,
  output reg exec_abort,
  output reg irq
);
  reg [15:0] initial_seq_value_q;
  reg [SEQ_WIDTH-1:0] expected_next_seq_q;
  reg [SEQ_WIDTH-1:0] expected_next_seq_d;
  reg [3:0] error_subtype_q;
  reg [3:0] error_subtype_d;
  reg [3:0] error_reason_q;
  reg [3:0] error_reason_d;
  reg [1:0] parser_state_q;
  reg [1:0] parser_state_d;
  reg read_path_active_q;
  reg write_path_active_q;
  reg enable_q;
  reg [`IRQ_WIDTH-1:0] irq_mask_q;
  reg [`IRQ_WIDTH-1:0] irq_event;
  wire [`IRQ_WIDTH-1:0] irq_status;
  wire irq_line;
  wire setup;
  wire access;
  wire wr_ctrl;
  wire wr_mask;
  wire rd_irq;
  wire restart_strobe;
  wire abort_strobe;
  wire enable_rise;
  wire known_addr;
  wire reason_ok;
  wire [31:0] command_parser_status;
  reg rd_act_d;
  reg wr_act_d;
  reg [31:0] rdata_d;

  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign known_addr = (paddr == `ADDR_ENGINE_CONTROL) | (paddr == `ADDR_PARSER_STATUS) |
                      (paddr == `ADDR_IRQ_STATUS) | (paddr == `ADDR_IRQ_MASK);
  assign wr_ctrl = access & pwrite & (paddr == `ADDR_ENGINE_CONTROL);
  assign wr_mask = access & pwrite & (paddr == `ADDR_IRQ_MASK);
  assign rd_irq = access & ~pwrite & (paddr == `ADDR_IRQ_STATUS);

  assign abort_strobe = wr_ctrl & pwdata[`CTRL_ABORT_BIT];
  assign restart_strobe = wr_ctrl & pwdata[`CTRL_RESTART_BIT];
  assign enable_rise = wr_ctrl & pwdata[`CTRL_ENABLE_BIT] & ~enable_q;

  assign reason_ok = (err_reason >= `REASON_BAD_CMD) & (err_reason <= `REASON_DP_ERR_LAST);

  assign command_parser_status = {expected_next_seq_q[15:0], 4'h0, error_subtype_q,
                                  error_reason_q, read_path_active_q, write_path_active_q,
                                  parser_state_q};

  // control word and irq mask: held fields only, strobes never stored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      initial_seq_value_q <= `SEQ_RESET;
      enable_q <= 1'b0;
      seq_check_en <= 1'b0;
      onecomp_check_en <= 1'b0;
      irq_mask_q <= `IRQ_RESET;
    end else begin
      if (wr_ctrl) begin
        initial_seq_value_q <= pwdata[`CTRL_SEQ_HI:`CTRL_SEQ_LO];
        enable_q <= pwdata[`CTRL_ENABLE_BIT];
        seq_check_en <= pwdata[`CTRL_SEQ_EN_BIT];
        onecomp_check_en <= pwdata[`CTRL_ONECOMP_BIT];
      end
      if (wr_mask) begin
        irq_mask_q <= pwdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  // parser state, sequence and error report
  always @* begin
    parser_state_d = parser_state_q;
    expected_next_seq_d = expected_next_seq_q;
    error_subtype_d = error_subtype_q;
    error_reason_d = error_reason_q;
    irq_event = {`IRQ_WIDTH{1'b0}};
    case (parser_state_q)
      `STATE_IDLE: begin
        if (err_valid && reason_ok) begin
          parser_state_d = `STATE_STALL;
          error_reason_d = err_reason;
          if (err_reason == `REASON_CMD_CHECK) begin
            error_subtype_d = err_check;
          end
          irq_event[`IRQ_ERROR_BIT] = 1'b1;
        end else if (cmd_start && enable_q) begin
          parser_state_d = `STATE_EXEC;
        end
      end
      `STATE_EXEC: begin
        if (err_valid && reason_ok) begin
          parser_state_d = `STATE_STALL;
          error_reason_d = err_reason;
          if (err_reason == `REASON_CMD_CHECK) begin
            error_subtype_d = err_check;
          end
          irq_event[`IRQ_ERROR_BIT] = 1'b1;
        end else if (cmd_done) begin
          parser_state_d = `STATE_IDLE;
          expected_next_seq_d = expected_next_seq_q + {{(SEQ_WIDTH-1){1'b0}}, 1'b1};
          irq_event[`IRQ_DONE_BIT] = 1'b1;
        end
      end
      `STATE_STALL: begin
        parser_state_d = `STATE_STALL;
      end
      default: begin
        parser_state_d = `STATE_IDLE;
      end
    endcase
    if (abort_strobe && !restart_strobe) begin
      if (parser_state_q == `STATE_IDLE) begin
        parser_state_d = `STATE_STALL;
        error_reason_d = `REASON_ABORT_IDLE;
        irq_event[`IRQ_ABORT_BIT] = 1'b1;
      end else if (parser_state_q == `STATE_EXEC) begin
        parser_state_d = `STATE_STALL;
        error_reason_d = `REASON_ABORT_EXEC;
        error_subtype_d = `NIBBLE_RESET;
        irq_event[`IRQ_ABORT_BIT] = 1'b1;
      end
    end
    if (restart_strobe) begin
      error_subtype_d = `NIBBLE_RESET;
      error_reason_d = `NIBBLE_RESET;
      parser_state_d = `STATE_IDLE;
      irq_event[`IRQ_ERROR_BIT] = 1'b0;
      irq_event[`IRQ_ABORT_BIT] = 1'b0;
      irq_event[`IRQ_DONE_BIT] = 1'b0;
    end
    if (restart_strobe || enable_rise) begin
      expected_next_seq_d = pwdata[`CTRL_SEQ_HI:`CTRL_SEQ_LO];
    end
  end

  // path activity, decided from the next state (parser_state_d)
  always @* begin
    rd_act_d = rd_outstanding | ~rd_fifo_empty;
    if (parser_state_d == `STATE_STALL) begin
      wr_act_d = cmds_pending | ~cmd_fifo_empty;
    end else begin
      wr_act_d = pix_conv_busy | cmds_pending | ~cmd_fifo_empty | ~data_fifo_empty;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parser_state_q <= `STATE_IDLE;
      expected_next_seq_q <= `SEQ_RESET;
      error_subtype_q <= `NIBBLE_RESET;
      error_reason_q <= `NIBBLE_RESET;
      read_path_active_q <= 1'b0;
      write_path_active_q <= 1'b0;
    end else begin
      parser_state_q <= parser_state_d;
      expected_next_seq_q <= expected_next_seq_d;
      error_subtype_q <= error_subtype_d;
      error_reason_q <= error_reason_d;
      read_path_active_q <= rd_act_d;
      write_path_active_q <= wr_act_d;
    end
  end

  // side effects toward the engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      engine_run_enable <= 1'b0;
      endpoint_stall <= 1'b0;
      pixel_flush <= 1'b0;
      exec_abort <= 1'b0;
      irq <= 1'b0;
    end else begin
      engine_run_enable <= wr_ctrl ? pwdata[`CTRL_ENABLE_BIT] : enable_q;
      endpoint_stall <= (parser_state_d == `STATE_STALL);
      pixel_flush <= restart_strobe;
      exec_abort <= abort_strobe & ~restart_strobe;
      irq <= irq_line;
    end
  end

  sticky_irq #(
    .WIDTH(`IRQ_WIDTH)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .event_set(irq_event),
    .mask(irq_mask_q),
    .read_clear(rd_irq),
    .status_q(irq_status),
    .irq_q(irq_line)
  );

  // read mux, sampled in the setup cycle
  always @* begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `ADDR_ENGINE_CONTROL: begin
        rdata_d[`CTRL_SEQ_HI:`CTRL_SEQ_LO] = initial_seq_value_q;
        rdata_d[`CTRL_ONECOMP_BIT] = onecomp_check_en;
        rdata_d[`CTRL_SEQ_EN_BIT] = seq_check_en;
        rdata_d[`CTRL_ENABLE_BIT] = enable_q;
      end
      `ADDR_PARSER_STATUS: begin
        rdata_d = command_parser_status;
      end
      `ADDR_IRQ_STATUS: begin
        rdata_d[`IRQ_WIDTH-1:0] = irq_status;
      end
      `ADDR_IRQ_MASK: begin
        rdata_d[`IRQ_WIDTH-1:0] = irq_mask_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // one access cycle per transfer; pready is a flop so it rises in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= ~known_addr | (pwrite & (paddr == `ADDR_PARSER_STATUS)) |
                   (pwrite & (paddr == `ADDR_IRQ_STATUS));
        prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // note: the irq status word is read before the clear lands, so events in the
  // access cycle stay set for the next read
endmodule

// file: gfx_parser_status_props.sv
// Purpose: port checks for the parser status block
// Assumes: one-cycle apb access, control word at 12'h000
// Notes: attached by bind below
`timescale 1ns/100ps
module gfx_parser_status_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire err_valid,
  input wire [3:0] err_reason,
  input wire engine_run_enable,
  input wire endpoint_stall,
  input wire pixel_flush
);
  wire wctl = psel && penable && pready && pwrite && paddr == 12'h000;
  wire rst_w = wctl && pwdata[1];
  wire abt_w = wctl && pwdata[2] && !pwdata[1];
  wire err_w = err_valid && err_reason > 4'h0 && err_reason < 4'h8;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_next_a:
  assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ro_refuse_a:
  assert property (psel && penable && pready && pwrite && paddr == 12'h004 |-> pslverr)
    else $error("status write not refused");
  err_stall_a:
  assert property (err_w && !endpoint_stall && !rst_w |=> endpoint_stall)
    else $error("error did not stall");
  rsvd_drop_a:
  assert property (err_valid && !err_w && !endpoint_stall && !wctl |=> !endpoint_stall)
    else $error("reserved reason stalled");
  abort_stall_a:
  assert property (abt_w |=> endpoint_stall) else $error("abort did not stall");
  stall_hold_a:
  assert property (endpoint_stall && !rst_w |=> endpoint_stall) else $error("stall lost");
  restart_flush_a:
  assert property (rst_w |=> !endpoint_stall && pixel_flush ##1 !pixel_flush)
    else $error("restart flush wrong");
  flush_cause_a:
  assert property (pixel_flush |-> $past(rst_w)) else $error("flush without restart");
  enable_hold_a:
  assert property (!wctl |=> $stable(engine_run_enable)) else $error("enable moved");
  cover property (rst_w);
  cover property (abt_w && !endpoint_stall);
  cover property (err_w && !endpoint_stall);
  cover property (pixel_flush ##1 !pixel_flush);
endmodule

bind gfx_parser_status gfx_parser_status_chk chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .err_valid, .err_reason, .engine_run_enable,
  .endpoint_stall, .pixel_flush);

// file: sticky_irq.v
// Purpose: sticky event bits with mask and one level interrupt
// Assumes: events are one-cycle pulses on pclk
// Notes: a set in the clearing cycle survives the clear
`timescale 1ns/100ps
module sticky_irq #(
  parameter WIDTH = 3
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] event_set,
  input wire [WIDTH-1:0] mask,
  input wire read_clear,
  output reg [WIDTH-1:0] status_q,
  output reg irq_q
);
  reg [WIDTH-1:0] status_d;

  always @* begin
    status_d = status_q;
    if (read_clear) begin
      status_d = {WIDTH{1'b0}};
    end
    // set wins over a clear in the same cycle
    status_d = status_d | event_set;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= {WIDTH{1'b0}};
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= |(status_d & mask);
    end
  end
endmodule

// file: testbench.sv
// Purpose: self-checking bench for the parser status block
// Assumes: one-cycle apb access, mask bit set lets that status bit raise irq
// Notes: control and sequence checks first, then error code rows, hand tests after
`timescale 1ns/100ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, cmd_start = 0, cmd_done = 0, err_valid = 0;
  logic [3:0] err_reason = 4'h0, err_check = 4'h0;
  logic [5:0] act = 6'h00;
  logic engine_run_enable, seq_check_en, onecomp_check_en;
  logic endpoint_stall, pixel_flush, exec_abort, irq;
  int miscompares = 0, tests_run = 0;
  // rows: reason, check, expected low half of status
  logic [23:0] rows [0:9] = '{24'h15_0012, 24'h25_0022, 24'h35_0032, 24'h49_0942,
    24'h55_0052, 24'h65_0062, 24'h75_0072, 24'h83_0000, 24'hd3_0000, 24'h03_0000};
  always #2.5 pclk = ~pclk;
  gfx_parser_status dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cmd_start, .cmd_done, .err_valid, .err_reason,
    .err_check, .rd_outstanding(act[0]), .rd_fifo_empty(!act[1]),
    .pix_conv_busy(act[2]), .cmds_pending(act[3]), .cmd_fifo_empty(!act[4]),
    .data_fifo_empty(!act[5]), .engine_run_enable, .seq_check_en, .onecomp_check_en,
    .endpoint_stall, .pixel_flush, .exec_abort, .irq);
  task chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // holds the request until pready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite} <= {2'b10, w};
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no fixed wait count: only the watchdog ends a hung access
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // bits: error, done, start
  task pulse(input logic [2:0] v);
    @(posedge pclk);
    {err_valid, cmd_done, cmd_start} <= v;
    @(posedge pclk);
    {err_valid, cmd_done, cmd_start} <= 3'b000;
  endtask
  task print_verdict;
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h1234_0019);
    rchk(12'h004, 32'h1234_0000);
    rchk(12'h000, 32'h1234_0019);
    chk({engine_run_enable, seq_check_en, onecomp_check_en}, 3'h7);
    apb(1'b1, 12'h000, 32'h5678_0001);
    rchk(12'h004, 32'h1234_0000);
    rchk(12'h000, 32'h5678_0001);
    pulse(3'b001);
    rchk(12'h004, 32'h1234_0001);
    pulse(3'b010);
    rchk(12'h004, 32'h1235_0000);
    apb(1'b1, 12'h000, 32'hffff_0003);
    pulse(3'b001);
    pulse(3'b010);
    rchk(12'h004, 32'h0);
    for (int i = 0; i < 10; i++) begin
      err_reason <= rows[i][23:20];
      err_check <= rows[i][19:16];
      pulse(3'b100);
      rchk(12'h004, {16'h0, rows[i][15:0]});
      apb(1'b1, 12'h000, 32'h3);
      rchk(12'h004, 32'h0);
    end
    // second pass runs stalled after an idle abort
    for (int s = 0; s < 2; s++) begin
      if (s) begin
        apb(1'b1, 12'h000, 32'h5);
        @(posedge pclk);
        chk(exec_abort, 1'b1);
      end
      for (int i = 0; i < 6; i++) begin
        act <= 6'h01 << i;
        rchk(12'h004, {24'h0, s ? 4'he : 4'h0, i < 2, i > 1 && !(s && (i == 2 || i == 5)),
          s ? 2'h2 : 2'h0});
      end
    end
    act <= 6'h00;
    apb(1'b1, 12'h000, 32'h3);
    pulse(3'b001);
    apb(1'b1, 12'h000, 32'h5);
    @(posedge pclk);
    chk(exec_abort, 1'b1);
    rchk(12'h004, 32'h0000_00f2);
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b1, 12'h004, 32'hffff_ffff);
    chk(se, 1'b1);
    rchk(12'h004, 32'h0);
    rchk(12'h100, 32'h0);
    chk(se, 1'b1);
    // mask is all clear after reset, so pending events stay off the line
    chk(irq, 1'b0);
    apb(1'b1, 12'h024, 32'h7);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    rchk(12'h024, 32'h7);
    rchk(12'h020, 32'h7);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, 12'h024, 32'h6);
    pulse(3'b001);
    pulse(3'b010);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, 12'h024, 32'h7);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    rchk(12'h020, 32'h1);
    // reset in mid-run while stalled
    apb(1'b1, 12'h000, 32'h5);
    @(posedge pclk);
    chk(endpoint_stall, 1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({endpoint_stall, engine_run_enable, irq, pready}, 4'h0);
    presetn <= 1'b1;
    rchk(12'h004, 32'h0);
    rchk(12'h000, 32'h0);
    print_verdict;
  end
  // whole run is a few hundred cycles
  initial begin
    #100000;
    miscompares++;
    print_verdict;
  end
endmodule
